/* File: bench/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk_i, // clock
	input wire logic [7:0] rdata_i, // read data
	output logic wr_o, // write strobe
	output logic rd_o, // read strobe
	output logic [7:0] addr_o, // address
	output logic [7:0] wdata_o // write data
);
	initial begin
		{wr_o, rd_o} = 2'b00;
		{addr_o, wdata_o} = 16'h0000;
	end
	// Released lines show the inverse so stale values never look valid.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		{addr_o, wdata_o, wr_o} = {a, d, 1'b1};
		@(negedge clk_i);
		{addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		{addr_o, rd_o} = {a, 1'b1};
		@(negedge clk_i);
		{addr_o, rd_o} = {~a, 1'b0};
		d = rdata_i;
	endtask : rd
endmodule : host_model
`default_nettype wire

/* File: bench/protect_regs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module protect_regs_checker
	import protect_cfg_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic reg_wr_i, // write
	input wire logic reg_rd_i, // read
	input wire logic [7:0] reg_addr_i, // address
	input wire logic [7:0] reg_wdata_i, // write data
	input wire logic [7:0] reg_rdata_o, // read data
	input wire logic reg_hit_o, // address decode
	input wire logic i2c_bus_active_i, // bus activity
	input wire logic i2c_bus_free_o, // bus free
	input wire logic i2c_fast_mode_o, // fast timing
	input wire logic indication_fast_o, // status mirror
	input wire logic repeater_mode_o, // repeater
	input wire logic enhanced_signaling_o, // enhanced scheme
	input wire logic av_mute_o, // mute
	input wire logic encrypt_enable_i, // enable request
	input wire logic encrypt_enable_o // effective enable
);
	logic [7:0] dbg;
	logic [7:0] cfg;
	logic [7:0] next_dbg;
	logic [7:0] next_cfg;
	// Shadow copies of both registers, built from the writes seen.
	always_comb begin
		next_dbg = dbg;
		next_cfg = cfg;
		if (reg_wr_i && reg_addr_i == DEBUG_CTRL_ADDR) next_dbg = reg_wdata_i & 8'h5f;
		if (reg_wr_i && reg_addr_i == CONFIG_ADDR) next_cfg = reg_wdata_i;
	end
	always_ff @(posedge clk_i) begin
		dbg <= rst_i ? 8'h00 : next_dbg;
		cfg <= rst_i ? CONFIG_RESET : next_cfg;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_rd_dbg;
		reg_rd_i && !reg_wr_i && reg_addr_i == DEBUG_CTRL_ADDR;
	endsequence
	property p_rd; s_rd_dbg |=> reg_rdata_o == dbg; endproperty
	a_rd: assert property (p_rd) else $error("debug readback wrong");
	property p_hit;
		reg_hit_o == (reg_addr_i == CONFIG_ADDR || reg_addr_i == DEBUG_CTRL_ADDR);
	endproperty
	a_hit: assert property (p_hit) else $error("address decode wrong");
	property p_tmo; dbg[6] |-> !i2c_bus_free_o; endproperty
	a_tmo: assert property (p_tmo) else $error("bus free while timeout off");
	property p_free; i2c_bus_active_i |=> !i2c_bus_free_o; endproperty
	a_free: assert property (p_free) else $error("bus free right after activity");
	property p_fast; i2c_fast_mode_o == dbg[0]; endproperty
	a_fast: assert property (p_fast) else $error("fast mode select wrong");
	property p_mir; indication_fast_o == i2c_fast_mode_o; endproperty
	a_mir: assert property (p_mir) else $error("fast mode mirror wrong");
	property p_sig; enhanced_signaling_o == cfg[6]; endproperty
	a_sig: assert property (p_sig) else $error("signaling scheme wrong");
	property p_rpt; repeater_mode_o == cfg[5]; endproperty
	a_rpt: assert property (p_rpt) else $error("repeater mode wrong");
	property p_mute; av_mute_o == (cfg[0] && cfg[6]); endproperty
	a_mute: assert property (p_mute) else $error("mute wrong");
	property p_enc; encrypt_enable_o == (encrypt_enable_i || cfg[4:3] == 2'h3); endproperty
	a_enc: assert property (p_enc) else $error("encrypt enable wrong");
endmodule : protect_regs_checker
bind content_protect_debug_config_regs protect_regs_checker chk_u (
	.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.reg_hit_o(reg_hit_o),
	.i2c_bus_active_i(i2c_bus_active_i), .i2c_bus_free_o(i2c_bus_free_o),
	.i2c_fast_mode_o(i2c_fast_mode_o), .indication_fast_o(indication_fast_o),
	.repeater_mode_o(repeater_mode_o), .enhanced_signaling_o(enhanced_signaling_o),
	.av_mute_o(av_mute_o), .encrypt_enable_i(encrypt_enable_i),
	.encrypt_enable_o(encrypt_enable_o)
);
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import protect_cfg_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr, rd, act, fs, lv, le, rdy, ast, det, lock, eni;
	logic free, fast, ind, spd, enh, lnk, syn, cv, rpt, sig, wdone, irq, mute, eno, ign;
	logic [7:0] addr, wd, rdat, fcnt;
	logic [23:0] pix, cks;
	int n_mismatch = 0;
	int tests_run = 0;
	always #5 clk = ~clk;
	host_model host_u (.clk_i(clk), .rdata_i(rdat), .wr_o(wr), .rd_o(rd), .addr_o(addr),
		.wdata_o(wd));
	content_protect_debug_config_regs #(.BUS_TIMEOUT_CYCLES(20), .WAIT_CYCLES(20)) dut_u (
		.clk_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_hit_o(), .i2c_bus_active_i(act),
		.i2c_bus_free_o(free), .i2c_fast_mode_o(fast), .indication_fast_o(ind),
		.timer_speedup_o(spd), .frame_start_i(fs), .enh_check_o(enh), .link_check_o(lnk),
		.sync_check_o(syn), .frame_count_o(fcnt), .line_valid_i(lv), .line_end_i(le),
		.pixel_i(pix), .checksum_ready_i(rdy), .checksum_valid_o(cv), .checksum_o(cks),
		.repeater_mode_o(rpt), .enhanced_signaling_o(sig), .auth_start_i(ast),
		.initial_wait_done_o(wdone), .rx_detect_i(det), .rx_lock_i(lock),
		.rx_detect_irq_o(irq), .av_mute_o(mute), .encrypt_enable_i(eni),
		.encrypt_enable_o(eno), .encrypt_status_ignore_o(ign));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	task automatic t_regs();
		logic [7:0] v;
		host_u.rd(DEBUG_CTRL_ADDR, v);
		chk(24'(v), 24'h0);
		host_u.wr(8'hc1, 8'hff);
		host_u.rd(8'hc1, v);
		chk(24'(v), 24'h0);
		host_u.wr(DEBUG_CTRL_ADDR, 8'hff);
		host_u.rd(DEBUG_CTRL_ADDR, v);
		chk(24'(v), 24'h5f);
		chk(24'({fast, ind, spd}), 24'h7);
		host_u.wr(DEBUG_CTRL_ADDR, 8'h00);
		chk(24'({fast, ind, spd}), 24'h0);
		$display("test regs done");
	endtask : t_regs
	task automatic t_timeout();
		@(negedge clk) act = 1'b1;
		@(negedge clk) act = 1'b0;
		repeat (10) @(negedge clk);
		chk(24'(free), 24'h0);
		repeat (15) @(negedge clk);
		chk(24'(free), 24'h1);
		host_u.wr(DEBUG_CTRL_ADDR, 8'h40);
		chk(24'(free), 24'h0);
		host_u.wr(DEBUG_CTRL_ADDR, 8'h00);
		$display("test timeout done");
	endtask : t_timeout
	task automatic t_cfg();
		host_u.wr(CONFIG_ADDR, 8'h60);
		chk(24'({rpt, sig, mute}), 24'h6);
		host_u.wr(CONFIG_ADDR, 8'h41);
		chk(24'({rpt, sig, mute, ign}), 24'h7);
		host_u.wr(CONFIG_ADDR, 8'h18);
		chk(24'({sig, mute, eno}), 24'h1);
		host_u.wr(CONFIG_ADDR, 8'h12);
		{det, lock} = 2'b10;
		repeat (2) @(negedge clk);
		chk(24'({eno, irq}), 24'h0);
		{lock, eni} = 2'b11;
		repeat (2) @(negedge clk);
		chk(24'({eno, irq}), 24'h3);
		host_u.wr(CONFIG_ADDR, 8'h00);
		{lock, eni} = 2'b00;
		repeat (2) @(negedge clk);
		chk(24'({eno, irq}), 24'h1);
		$display("test config done");
	endtask : t_cfg
	task automatic t_wait(input logic [7:0] c, input logic e);
		host_u.wr(CONFIG_ADDR, c);
		@(negedge clk) ast = 1'b1;
		@(negedge clk) ast = 1'b0;
		repeat (10) @(negedge clk);
		chk(24'(wdone), 24'(e));
		repeat (15) @(negedge clk);
		chk(24'(wdone), 24'h1);
		$display("test wait done");
	endtask : t_wait
	task automatic t_sum();
		host_u.wr(DEBUG_CTRL_ADDR, 8'h08);
		@(negedge clk) {lv, pix} = {1'b1, 24'hff8001};
		@(negedge clk) pix = 24'h0180ff;
		@(negedge clk) {lv, le} = 2'b01;
		@(negedge clk) le = 1'b0;
		for (int i = 0; i < 5 && cv !== 1'b1; i++) @(negedge clk);
		if (cv !== 1'b1) begin
			n_mismatch++;
			$display("[FAIL] t=%0t checksum never became valid", $time);
			test_done();
		end
		chk(cks, 24'hfefefe);
		@(negedge clk) rdy = 1'b1;
		@(negedge clk) rdy = 1'b0;
		chk(24'(cv), 24'h0);
		$display("test checksum done");
	endtask : t_sum
	task automatic t_frames(input logic [7:0] d, c, input int n, el, ee, es, ef);
		int cl = 0;
		int ce = 0;
		int cs = 0;
		host_u.wr(DEBUG_CTRL_ADDR, d);
		host_u.wr(CONFIG_ADDR, c);
		for (int i = 0; i < 2 * n + 4; i++) begin
			@(negedge clk);
			fs = (i < 2 * n) && (i % 2 == 0);
			cl += int'(lnk === 1'b1);
			ce += int'(enh === 1'b1);
			cs += int'(syn === 1'b1);
		end
		chk(24'(cl), 24'(el));
		chk(24'(ce), 24'(ee));
		chk(24'(cs), 24'(es));
		chk(24'(fcnt), 24'(ef));
		$display("test frames done");
	endtask : t_frames
	task automatic t_reset();
		logic [7:0] v;
		host_u.wr(CONFIG_ADDR, 8'hfe);
		host_u.rd(CONFIG_ADDR, v);
		chk(24'(v), 24'hfe);
		@(negedge clk) rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		chk(24'(fcnt), 24'h0);
		host_u.rd(CONFIG_ADDR, v);
		chk(24'(v), 24'(CONFIG_RESET));
		host_u.rd(DEBUG_CTRL_ADDR, v);
		chk(24'(v), 24'(DEBUG_CTRL_RESET));
		$display("test reset done");
	endtask : t_reset
	initial begin
		{act, fs, lv, le, rdy, ast, det, lock, eni} = '0;
		pix = '0;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		t_regs();
		t_timeout();
		t_cfg();
		t_wait(8'h00, 1'b1);
		t_wait(8'h04, 1'b0);
		t_sum();
		t_frames(8'h00, 8'h80, 256, 2, 16, 2, 0);
		t_frames(8'h10, 8'h00, 256, 2, 0, 0, 0);
		t_frames(8'h04, 8'h80, 32, 2, 16, 2, 32);
		t_reset();
		test_done();
	end
endmodule : tb
`default_nettype wire

/* File: core/content_protect_debug_config_regs.sv */
// Contract
// - Timeout-disable bit set stops the embedded I2C master bus-idle timeout.
// - With timeout enabled, bus counts as free after one second idle.
// - By default check link integrity at frames 127 and 128.
// - Sync-check-disable bit skips the frame 127 check, keeps the later one.
// - Line-checksum bit sends ones-complement checksum per colour channel each line.
// - Frame-counter test: enhanced value every 2, integrity every 16 frames.
// - Normal counting: enhanced value every 16, integrity every 128 frames.
// - Timer-speedup bit shortens authentication timers.
// - Debug bit 0 selects fast-mode I2C timing, else standard mode.
// - Fast-mode bit mirrored in the indication status register.
// - Enhanced-verification bit enables check on every 16th frame.
// - Config bit 6 selects original or enhanced status signaling.
// - Repeater bit enables extra repeater authentication steps.
// - Wait 100 ms for receiver computations only when config bit 2 set.
// - Detect-select adds receiver lock to the receiver-detect interrupt.
// - Mute bit starts audio/video mute, ignoring encryption status controls, only while config bit 6 selects enhanced signaling.
// - Always-encrypt mode forces the encryption-enable control to read 1.
`timescale 1ns/1ps
`default_nettype none
module content_protect_debug_config_regs
	import protect_cfg_pkg::*;
#(
	parameter int BUS_TIMEOUT_CYCLES = TIMEOUT_CYCLES,
	parameter int WAIT_CYCLES = INIT_WAIT_CYCLES
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic reg_wr_i, // register write strobe
	input wire logic reg_rd_i, // register read strobe
	input wire logic [7:0] reg_addr_i, // register address
	input wire logic [7:0] reg_wdata_i, // write data
	output logic [7:0] reg_rdata_o, // read data
	output logic reg_hit_o, // address is one of ours
	input wire logic i2c_bus_active_i, // embedded I2C activity seen
	output logic i2c_bus_free_o, // master may assume bus free
	output logic i2c_fast_mode_o, // fast timing select
	output logic indication_fast_o, // mirror for status register
	output logic timer_speedup_o, // shorten authentication timers
	input wire logic frame_start_i, // one pulse per frame
	output logic enh_check_o, // enhanced value check pulse
	output logic link_check_o, // link integrity check pulse
	output logic sync_check_o, // early sync check pulse
	output logic [7:0] frame_count_o, // frame counter
	input wire logic line_valid_i, // active video pixel
	input wire logic line_end_i, // end of active line
	input wire logic [23:0] pixel_i, // colour channels
	input wire logic checksum_ready_i, // consumer takes checksum
	output logic checksum_valid_o, // checksum available
	output logic [23:0] checksum_o, // per-channel checksums
	output logic repeater_mode_o, // repeater steps active
	output logic enhanced_signaling_o, // enhanced status scheme
	input wire logic auth_start_i, // authentication begins
	output logic initial_wait_done_o, // receiver compute wait over
	input wire logic rx_detect_i, // downstream receiver detected
	input wire logic rx_lock_i, // receiver lock indication
	output logic rx_detect_irq_o, // receiver-detect interrupt level
	output logic av_mute_o, // mute active
	input wire logic encrypt_enable_i, // requested encryption enable
	output logic encrypt_enable_o, // effective encryption enable
	output logic encrypt_status_ignore_o // status controls ignored
);
	debug_ctrl_s dbg;
	debug_ctrl_s next_dbg;
	config_s cfg;
	config_s next_cfg;
	logic [7:0] rdata;
	logic [7:0] next_rdata;

	function automatic logic [7:0] ones_sum(input logic [7:0] acc, input logic [7:0] val);
		logic [8:0] s;
		s = {1'b0, acc} + {1'b0, val};
		ones_sum = s[7:0] + {7'h0, s[8]};
	endfunction : ones_sum

	function automatic logic [7:0] dbg_word(input debug_ctrl_s d);
		dbg_word = {1'b0, d.i2c_timeout_disable, 1'b0, d.sync_check_disable,
			d.line_checksum_enable, d.frame_counter_test, d.timer_speedup, d.i2c_fast_mode};
	endfunction : dbg_word

	// Periods are powers of two, so the phase is a mask rather than a divide.
	function automatic logic [7:0] frame_phase(input logic [7:0] count, input logic [7:0] period);
		frame_phase = count & (period - 8'h1);
	endfunction : frame_phase

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == DEBUG_CTRL_ADDR) || (a == CONFIG_ADDR);
	endfunction : addr_hit

	always_comb begin
		next_dbg = dbg;
		next_cfg = cfg;
		next_rdata = rdata;
		if (reg_wr_i && reg_addr_i == DEBUG_CTRL_ADDR) begin
			next_dbg.i2c_timeout_disable = reg_wdata_i[DBG_TIMEOUT_DIS_BIT];
			next_dbg.sync_check_disable = reg_wdata_i[DBG_SYNC_DIS_BIT];
			next_dbg.line_checksum_enable = reg_wdata_i[DBG_CHECKSUM_BIT];
			next_dbg.frame_counter_test = reg_wdata_i[DBG_FC_TEST_BIT];
			next_dbg.timer_speedup = reg_wdata_i[DBG_SPEEDUP_BIT];
			next_dbg.i2c_fast_mode = reg_wdata_i[DBG_FAST_BIT];
		end
		if (reg_wr_i && reg_addr_i == CONFIG_ADDR) begin
			next_cfg = config_s'(reg_wdata_i);
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				DEBUG_CTRL_ADDR: begin
					next_rdata = dbg_word(dbg) & DEBUG_CTRL_WMASK;
				end
				CONFIG_ADDR: begin
					next_rdata = 8'(cfg);
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dbg <= debug_ctrl_s'({DEBUG_CTRL_RESET[DBG_TIMEOUT_DIS_BIT],
				DEBUG_CTRL_RESET[DBG_SYNC_DIS_BIT:0]});
			cfg <= config_s'(CONFIG_RESET);
			rdata <= 8'h00;
		end else begin
			dbg <= next_dbg;
			cfg <= next_cfg;
			rdata <= next_rdata;
		end
	end

	assign reg_rdata_o = rdata;
	assign reg_hit_o = addr_hit(reg_addr_i);

	// Any bus activity restarts the idle count, and so does clearing the disable bit.
	// idle timeout
	protect_timeout_counter #(
		.LIMIT(BUS_TIMEOUT_CYCLES)
	) bus_idle_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(!dbg.i2c_timeout_disable),
		.restart_i(i2c_bus_active_i),
		.done_o(i2c_bus_free_o)
	);

	assign i2c_fast_mode_o = dbg.i2c_fast_mode;
	assign indication_fast_o = dbg.i2c_fast_mode;
	assign timer_speedup_o = dbg.timer_speedup;
	assign repeater_mode_o = cfg.repeater_enable;
	assign enhanced_signaling_o = cfg.enhanced_status_signaling;

	logic [7:0] frame_count;
	logic [7:0] next_frame_count;
	check_pulse_s checks;
	check_pulse_s next_checks;
	logic [7:0] enh_period;
	logic [7:0] link_period;

	always_comb begin
		enh_period = dbg.frame_counter_test ? ENH_PERIOD_TEST : ENH_PERIOD_NORMAL;
		link_period = dbg.frame_counter_test ? LINK_PERIOD_TEST : LINK_PERIOD_NORMAL;
		next_frame_count = frame_count;
		next_checks = '0;
		if (frame_start_i) begin
			next_frame_count = frame_count + 8'h1;
			next_checks.enh_check = cfg.enhanced_verification
				&& (frame_phase(next_frame_count, enh_period) == 8'h0);
			next_checks.link_check = frame_phase(next_frame_count, link_period) == 8'h0;
			next_checks.sync_check = !dbg.sync_check_disable
				&& (frame_phase(next_frame_count, link_period) == (link_period - 8'h1));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_count <= 8'h00;
			checks <= '0;
		end else begin
			frame_count <= next_frame_count;
			checks <= next_checks;
		end
	end

	assign enh_check_o = checks.enh_check;
	assign link_check_o = checks.link_check;
	assign sync_check_o = checks.sync_check;
	assign frame_count_o = frame_count;

	logic [23:0] acc;
	logic [23:0] next_acc;
	logic [23:0] line_sum;
	logic [23:0] sum_out;
	logic [23:0] next_sum_out;
	logic sum_valid;
	logic next_sum_valid;

	always_comb begin
		// A pixel that arrives together with the line end still belongs to that line.
		line_sum = acc;
		if (line_valid_i) begin
			for (int c = 0; c < 3; c++) begin
				line_sum[c*8 +: 8] = ones_sum(acc[c*8 +: 8], pixel_i[c*8 +: 8]);
			end
		end
		next_acc = line_sum;
		next_sum_out = sum_out;
		next_sum_valid = sum_valid && !checksum_ready_i;
		if (line_end_i) begin
			next_acc = 24'h0;
			if (dbg.line_checksum_enable) begin
				next_sum_out = ~line_sum;
				next_sum_valid = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc <= 24'h0;
			sum_out <= 24'h0;
			sum_valid <= 1'b0;
		end else begin
			acc <= next_acc;
			sum_out <= next_sum_out;
			sum_valid <= next_sum_valid;
		end
	end

	assign checksum_o = sum_out;
	assign checksum_valid_o = sum_valid;

	logic wait_run;
	logic next_wait_run;
	logic wait_done;

	always_comb begin
		next_wait_run = wait_run;
		if (auth_start_i) begin
			next_wait_run = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wait_run <= 1'b0;
		end else begin
			wait_run <= next_wait_run;
		end
	end

	protect_timeout_counter #(
		.LIMIT(WAIT_CYCLES)
	) init_wait_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(wait_run && cfg.initial_wait_enable),
		.restart_i(auth_start_i),
		.done_o(wait_done)
	);
	assign initial_wait_done_o = !cfg.initial_wait_enable || wait_done;

	// Detect and lock come from the link side, so each passes two flops first.
	logic [1:0] det_sync;
	logic [1:0] next_det_sync;
	logic [1:0] lock_sync;
	logic [1:0] next_lock_sync;

	always_comb begin
		next_det_sync = {det_sync[0], rx_detect_i};
		next_lock_sync = {lock_sync[0], rx_lock_i};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			det_sync <= 2'h0;
			lock_sync <= 2'h0;
		end else begin
			det_sync <= next_det_sync;
			lock_sync <= next_lock_sync;
		end
	end

	assign rx_detect_irq_o = det_sync[1] && (!cfg.detect_select || lock_sync[1]);

	assign av_mute_o = cfg.av_mute && cfg.enhanced_status_signaling;
	assign encrypt_status_ignore_o = av_mute_o;
	assign encrypt_enable_o = (cfg.enc_mode == ENC_MODE_ALWAYS) || encrypt_enable_i;
endmodule : content_protect_debug_config_regs
`default_nettype wire

/* File: core/protect_cfg_pkg.sv */
package protect_cfg_pkg;
	localparam logic [7:0] DEBUG_CTRL_ADDR = 8'hc0;
	localparam logic [7:0] CONFIG_ADDR = 8'hc2;
	localparam logic [7:0] DEBUG_CTRL_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] DEBUG_CTRL_WMASK = 8'h5f;
	localparam int DBG_TIMEOUT_DIS_BIT = 6;
	localparam int DBG_SYNC_DIS_BIT = 4;
	localparam int DBG_CHECKSUM_BIT = 3;
	localparam int DBG_FC_TEST_BIT = 2;
	localparam int DBG_SPEEDUP_BIT = 1;
	localparam int DBG_FAST_BIT = 0;
	localparam int CFG_ENHANCED_VERIFICATION_BIT = 7;
	localparam int CFG_EESS_BIT = 6;
	localparam int CFG_RPTR_BIT = 5;
	localparam int CFG_MODE_HI = 4;
	localparam int CFG_MODE_LO = 3;
	localparam int CFG_WAIT_BIT = 2;
	localparam int CFG_DET_SEL_BIT = 1;
	localparam int CFG_MUTE_BIT = 0;
	localparam logic [1:0] ENC_MODE_ALWAYS = 2'h3;
	localparam int CLK_MHZ = 100;
	localparam int TIMEOUT_MS = 1000;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_MHZ * 1000;
	localparam int INIT_WAIT_MS = 100;
	localparam int INIT_WAIT_CYCLES = INIT_WAIT_MS * CLK_MHZ * 1000;
	localparam logic [7:0] ENH_PERIOD_NORMAL = 8'd16;
	localparam logic [7:0] ENH_PERIOD_TEST = 8'd2;
	localparam logic [7:0] LINK_PERIOD_NORMAL = 8'd128;
	localparam logic [7:0] LINK_PERIOD_TEST = 8'd16;
	localparam logic [7:0] SYNC_FRAME_NUM = 8'd127;
	localparam logic [7:0] LINE_FRAME_NUM = 8'd128;

	typedef struct packed {
		logic i2c_timeout_disable;
		logic sync_check_disable;
		logic line_checksum_enable;
		logic frame_counter_test;
		logic timer_speedup;
		logic i2c_fast_mode;
	} debug_ctrl_s;

	typedef struct packed {
		logic enhanced_verification;
		logic enhanced_status_signaling;
		logic repeater_enable;
		logic [1:0] enc_mode;
		logic initial_wait_enable;
		logic detect_select;
		logic av_mute;
	} config_s;

	typedef struct packed {
		logic enh_check;
		logic link_check;
		logic sync_check;
	} check_pulse_s;
endpackage : protect_cfg_pkg

/* File: core/protect_timeout_counter.sv */
`timescale 1ns/1ps
`default_nettype none
// Counts enabled cycles and holds done high once the limit is reached.
module protect_timeout_counter
	import protect_cfg_pkg::*;
#(
	parameter int LIMIT = 1000
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic run_i, // count while high
	input wire logic restart_i, // reload to zero
	output logic done_o // high once limit reached
);
	logic [31:0] count;
	logic [31:0] next_count;

	always_comb begin
		next_count = count;
		if (restart_i || !run_i) begin
			next_count = 32'h0;
		end else if (count < 32'(LIMIT)) begin
			next_count = count + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count <= 32'h0;
		end else begin
			count <= next_count;
		end
	end

	assign done_o = run_i && (count >= 32'(LIMIT));
endmodule : protect_timeout_counter
`default_nettype wire
